// *** logic/pwic_defs.svh ***
// constants for the port wakeup and interrupt control block
`ifndef PWIC_DEFS_SVH
`define PWIC_DEFS_SVH

// mode register values that route a port-control move
`define PWIC_MODE_CMP     8'h18
`define PWIC_MODE_PEND    8'h19
`define PWIC_MODE_EDGE    8'h1A
`define PWIC_MODE_ENABLE  8'h1B

// reset values
`define PWIC_ENABLE_RST   8'hFF
`define PWIC_EDGE_RST     8'hFF

// status page select field, bits 7..5
`define PWIC_PAGE_MASK    8'hE0

// program addresses
`define PWIC_PC_W         12
`define PWIC_ISR_VECTOR   12'h000
`define PWIC_PC_MAX       12'hFFF

// number of timer interrupt sources, three per timer
`define PWIC_TMR_SRC      6

`endif

// *** logic/pwic_pkg.sv ***
// types shared by the port wakeup and interrupt control block
`include "pwic_defs.svh"

package pwic_pkg;

  typedef logic [7:0]             byte_t;
  typedef logic [`PWIC_PC_W-1:0]  pc_t;

  // core sequencing state, one-hot
  typedef enum logic [2:0] {
    ST_RUN     = 3'b001,
    ST_SERVICE = 3'b010,
    ST_SLEEP   = 3'b100
  } core_state_t;

  // registers saved on interrupt entry
  typedef struct packed {
    pc_t   pc;
    byte_t fptr;
    byte_t status;
    byte_t mode;
    byte_t w;
  } shadow_t;

endpackage : pwic_pkg

// *** logic/pwic_edge_if.sv ***
// carrier between the edge detector and the control core
`timescale 1ns/10ps

interface pwic_edge_if;
  import pwic_pkg::*;

  byte_t edge_sel;  // 1 = falling, 0 = rising
  byte_t edge_hit;  // one-cycle pulse per pin on the selected edge

  modport det
  (
    input  edge_sel,
    output edge_hit
  );

  modport core
  (
    output edge_sel,
    input  edge_hit
  );

endinterface : pwic_edge_if

// *** logic/pwic_edge_detect.sv ***
// port pin synchroniser and selectable edge detector
`timescale 1ns/10ps

module pwic_edge_detect
(
  input  wire logic          clk_i,   // core clock
  input  wire logic          rst_i,   // synchronous reset, active high
  input  wire pwic_pkg::byte_t pins_i, // raw port pins
  pwic_edge_if.det           eif      // edge select in, hits out
);
  import pwic_pkg::*;

  byte_t      meta_r;   // first stage, read only by sync_r
  byte_t      sync_r;
  byte_t      prev_r;
  logic [1:0] fill_r;   // history valid after two samples

  ////////////////////////////////////////////////////////////////////
  // two-stage synchroniser plus history sample
  always_ff @(posedge clk_i)
  begin
    meta_r <= pins_i;
    sync_r <= meta_r;
    prev_r <= sync_r;
  end

  // suppress false edges until the history holds real pin samples
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fill_r <= 2'b00;
    else
      fill_r <= {fill_r[0], 1'b1};
  end

  ////////////////////////////////////////////////////////////////////
  // selected transition per pin
  always_comb
  begin
    if (fill_r[1])
      eif.edge_hit = (eif.edge_sel & prev_r & ~sync_r)
                   | (~eif.edge_sel & ~prev_r & sync_r);
    else
      eif.edge_hit = 8'h00;
  end

  a_edge_fall_only: assert property (@(posedge clk_i) disable iff (rst_i)
    ((eif.edge_hit & eif.edge_sel & sync_r) == 8'h00))
    else $error("falling edge hit with pin high");

endmodule : pwic_edge_detect

// *** logic/port_wakeup_interrupt_control.sv ***
// port wakeup, external interrupt and interrupt entry/return control
`timescale 1ns/10ps
`include "pwic_defs.svh"

module port_wakeup_interrupt_control
(
  input  wire logic             REF_CLK_I,      // core clock, 100 MHz
  input  wire logic             RESET_I,        // synchronous reset, active high
  input  wire pwic_pkg::byte_t  PORTB_I,        // port pins, asynchronous
  input  wire logic             MOVE_I,         // port-control move strobe
  input  wire pwic_pkg::byte_t  MODE_I,         // mode register value
  input  wire pwic_pkg::byte_t  W_I,            // working accumulator
  input  wire pwic_pkg::byte_t  CMP_I,          // comparator result value
  output logic                  XCHG_O,         // pulse: load accumulator
  output pwic_pkg::byte_t       XCHG_DATA_O,    // value swapped out
  output pwic_pkg::byte_t       WAKE_PEND_O,    // pending flags view
  input  wire logic             SLEEP_I,        // sleep instruction pulse
  input  wire logic             WDT_OVF_I,      // watchdog overflow pulse
  output logic                  POWER_DOWN_O,   // in power down
  output logic                  WAKE_O,         // pulse: wake restart
  output pwic_pkg::pc_t         RESTART_PC_O,   // restart address
  input  wire logic             CNT_WRAP_I,     // counter wrap pulse
  input  wire logic             CNT_IRQ_EN_I,   // counter interrupt enable
  input  wire logic             CNT_PEND_CLR_I, // clear counter pending
  output logic                  CNT_PEND_O,     // counter pending flag
  input  wire logic [`PWIC_TMR_SRC-1:0] TMR_EVENT_I, // timer event pulses
  input  wire logic             BOUNDARY_I,     // instruction boundary
  input  wire pwic_pkg::pc_t    PC_I,           // current program counter
  input  wire pwic_pkg::byte_t  FPTR_I,         // current pointer
  input  wire pwic_pkg::byte_t  STATUS_I,       // current status
  input  wire logic             RETURN_I,       // interrupt return pulse
  input  wire logic             RETURN_ADD_I,   // add-variant return pulse
  output logic                  VECTOR_O,       // pulse: jump to routine
  output pwic_pkg::pc_t         VEC_PC_O,       // routine address
  output pwic_pkg::byte_t       VEC_STATUS_O,   // status with pages cleared
  output logic                  RESTORE_O,      // pulse: restore registers
  output pwic_pkg::pc_t         RST_PC_O,       // restored counter
  output pwic_pkg::byte_t       RST_FPTR_O,     // restored pointer
  output pwic_pkg::byte_t       RST_STATUS_O,   // restored status
  output pwic_pkg::byte_t       RST_MODE_O,     // restored mode
  output pwic_pkg::byte_t       RST_W_O,        // restored accumulator
  output logic                  CNT_ADD_O,      // pulse: add to counter
  output pwic_pkg::byte_t       CNT_ADD_VAL_O,  // amount to add
  output logic                  IN_SERVICE_O    // routine running
);
  import pwic_pkg::*;

  core_state_t state_r;
  core_state_t state_nxt;
  byte_t       en_mask_r;
  byte_t       edge_sel_r;
  byte_t       pend_r;
  byte_t       pend_nxt;
  byte_t       hit;
  logic        cnt_pend_r;
  logic        tmr_req_r;
  logic        irq_any;
  logic        ack;
  logic        ret;
  logic        wake_hit;
  logic        mv_pend;
  logic        mv_cmp;
  shadow_t     shadow_r;
  byte_t       vec_status_r;
  logic        pend_known_r;
  pwic_edge_if eif ();

  ////////////////////////////////////////////////////////////////////
  // pin edges
  pwic_edge_detect u_edge
  (
    .clk_i  (REF_CLK_I),
    .rst_i  (RESET_I),
    .pins_i (PORTB_I),
    .eif    (eif)
  );

  assign eif.edge_sel = edge_sel_r;

  // only unmasked pins count
  assign hit      = eif.edge_hit & ~en_mask_r;
  assign wake_hit = |hit;

  // move target decode
  assign mv_pend = MOVE_I && (MODE_I == `PWIC_MODE_PEND);
  assign mv_cmp  = MOVE_I && (MODE_I == `PWIC_MODE_CMP);

  ////////////////////////////////////////////////////////////////////
  // edge select and enable mask, plain copies from the accumulator
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      en_mask_r  <= `PWIC_ENABLE_RST;
      edge_sel_r <= `PWIC_EDGE_RST;
    end
    else if (MOVE_I)
    begin
      if (MODE_I == `PWIC_MODE_EDGE)
        edge_sel_r <= W_I;
      if (MODE_I == `PWIC_MODE_ENABLE)
        en_mask_r  <= W_I;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pending flags: a new edge wins over a clearing write
  always_comb
  begin
    pend_nxt = mv_pend ? W_I : pend_r;
    pend_nxt = pend_nxt | hit;
  end

  // no reset here: contents are undefined until software clears them
  always_ff @(posedge REF_CLK_I)
  begin
    pend_r <= pend_nxt;
  end

  assign WAKE_PEND_O = pend_r;

  ////////////////////////////////////////////////////////////////////
  // exchange answer one cycle after the move; pending is known once written
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      XCHG_O       <= 1'b0;
      XCHG_DATA_O  <= 8'h00;
      pend_known_r <= 1'b0;
    end
    else
    begin
      pend_known_r <= pend_known_r | mv_pend;
      XCHG_O <= mv_pend | mv_cmp;
      if (mv_pend)
        XCHG_DATA_O <= pend_r;
      else if (mv_cmp)
        XCHG_DATA_O <= CMP_I;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter wrap pending; a wrap wins over a clear
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      cnt_pend_r <= 1'b0;
    else if (CNT_WRAP_I)
      cnt_pend_r <= 1'b1;
    else if (CNT_PEND_CLR_I)
      cnt_pend_r <= 1'b0;
  end

  assign CNT_PEND_O = cnt_pend_r;

  // timer events are only caught while code runs outside a routine
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      tmr_req_r <= 1'b0;
    else if (ack)
      tmr_req_r <= 1'b0;
    else if ((state_r == ST_RUN) && (|TMR_EVENT_I))
      tmr_req_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////
  // request merge: all sources equal, any one is enough
  assign irq_any = (|(pend_r & ~en_mask_r))
                 | (cnt_pend_r & CNT_IRQ_EN_I)
                 | tmr_req_r;
  // entry only in normal running, never nested or in power down
  assign ack = (state_r == ST_RUN) && BOUNDARY_I && irq_any && !SLEEP_I;
  assign ret = (state_r == ST_SERVICE) && (RETURN_I || RETURN_ADD_I);
  ////////////////////////////////////////////////////////////////////
  // sequencing state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
      begin
        if (ack)
          state_nxt = ST_SERVICE;
        else if (SLEEP_I)
          state_nxt = ST_SLEEP;
      end
      ST_SERVICE:
      begin
        if (ret)
          state_nxt = ST_RUN;
      end
      ST_SLEEP:
      begin
        if (WDT_OVF_I || wake_hit)
          state_nxt = ST_RUN;
      end
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  assign POWER_DOWN_O = (state_r == ST_SLEEP);
  assign IN_SERVICE_O = (state_r == ST_SERVICE);
  ////////////////////////////////////////////////////////////////////
  // wake restart, same address as reset
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      WAKE_O       <= 1'b0;
      RESTART_PC_O <= `PWIC_PC_MAX;
    end
    else
    begin
      WAKE_O       <= (state_r == ST_SLEEP) && (WDT_OVF_I || wake_hit);
      RESTART_PC_O <= `PWIC_PC_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // single-level stack and shadows, apart from the call stack
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      shadow_r     <= '0;
      vec_status_r <= 8'h00;
    end
    else if (ack)
    begin
      shadow_r     <= '{pc: PC_I, fptr: FPTR_I, status: STATUS_I,
                        mode: MODE_I, w: W_I};
      vec_status_r <= STATUS_I & ~`PWIC_PAGE_MASK;
    end
  end

  // entry pulse and fixed vector
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      VECTOR_O <= 1'b0;
    else
      VECTOR_O <= ack;
  end

  assign VEC_PC_O     = `PWIC_ISR_VECTOR;
  assign VEC_STATUS_O = vec_status_r;

  // return pulses; restored values stand in the shadow flops
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      RESTORE_O <= 1'b0;
      CNT_ADD_O <= 1'b0;
    end
    else
    begin
      RESTORE_O <= ret;
      CNT_ADD_O <= (state_r == ST_SERVICE) && RETURN_ADD_I;
    end
  end

  assign RST_PC_O      = shadow_r.pc;
  assign RST_FPTR_O    = shadow_r.fptr;
  assign RST_STATUS_O  = shadow_r.status;
  assign RST_MODE_O    = shadow_r.mode;
  assign RST_W_O       = shadow_r.w;
  assign CNT_ADD_VAL_O = shadow_r.w;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  a_reset_values: assert property (disable iff (1'b0) RESET_I |=>
    (en_mask_r == `PWIC_ENABLE_RST) && (edge_sel_r == `PWIC_EDGE_RST))
    else $error("mask or edge select wrong after reset");
  a_pend_latch: assert property ((hit != 8'h00) |=>
    ((pend_r & $past(hit)) == $past(hit)))
    else $error("enabled edge not latched");
  a_masked_ignored: assert property (pend_known_r && !mv_pend |=>
    ((pend_r & ~$past(pend_r) & $past(en_mask_r)) == 8'h00))
    else $error("masked pin set pending");
  a_pend_swap: assert property (mv_pend && pend_known_r |=>
    XCHG_O && (XCHG_DATA_O == $past(pend_r)))
    else $error("pending exchange wrong");
  a_edge_copy: assert property (MOVE_I && (MODE_I == `PWIC_MODE_EDGE) |=>
    !XCHG_O && (edge_sel_r == $past(W_I)))
    else $error("edge select copy wrong");
  a_entry_vector: assert property (ack |=> VECTOR_O && (VEC_PC_O == `PWIC_ISR_VECTOR)
    && ((VEC_STATUS_O & `PWIC_PAGE_MASK) == 8'h00) && (RST_PC_O == $past(PC_I)))
    else $error("entry vector or shadow wrong");
  a_no_nesting: assert property ((state_r == ST_SERVICE) && !ret |=> !VECTOR_O[*2])
    else $error("nested interrupt entry");
  a_return_add: assert property ((state_r == ST_SERVICE) && RETURN_ADD_I |=>
    RESTORE_O && CNT_ADD_O && (CNT_ADD_VAL_O == RST_W_O))
    else $error("add-variant return wrong");
  a_timer_gate: assert property ((state_r != ST_RUN) && !tmr_req_r |=> !tmr_req_r)
    else $error("timer request taken in routine");
  a_wake_restart: assert property ((state_r == ST_SLEEP) && wake_hit |=>
    WAKE_O && (RESTART_PC_O == `PWIC_PC_MAX) && (state_r == ST_RUN))
    else $error("wake restart wrong");

endmodule : port_wakeup_interrupt_control

// *** tb/port_pin_model.sv ***
// port pin model: drives the port pins with an asynchronous skew
`timescale 1ns/10ps

module port_pin_model
(
  input  wire logic [7:0] lvl_i,  // levels the pins should take
  output logic [7:0]      pins_o  // port pins seen by the block
);
  ////////////////////////////////////////
  // pins idle high, then follow each level with an odd skew
  // so that pin changes stay away from the clock edge, as a real pin would
  initial
  begin
    pins_o = 8'hFF;
    forever
    begin
      @(lvl_i);
      pins_o <= #3.3 lvl_i;
    end
  end
endmodule : port_pin_model

// *** tb/tb_top.sv ***
// self-checking bench for the port wakeup and interrupt control block
`timescale 1ns/10ps
`include "pwic_defs.svh"

module tb_top;
  import pwic_pkg::*;

  logic  clk, rst, mv, slp, wdt, wrp, cen, cclr, bnd, rti, rtw;
  logic  xo, pdo, wko, cpo, vo, ro, cao, iso;
  byte_t mode, w, cmp, fptr, st, lvl, xd, wp, vs, rf, rs, rm, rw, cav;
  byte_t ep, ed, en, sw;
  pc_t   pc, rpc, vpc, rp;
  logic [`PWIC_TMR_SRC-1:0] tev;
  wire byte_t pins;
  int    bad_count, checked;

  port_pin_model PINS (.lvl_i(lvl), .pins_o(pins));

  port_wakeup_interrupt_control DUT
  (
    .REF_CLK_I(clk), .RESET_I(rst), .PORTB_I(pins), .MOVE_I(mv), .MODE_I(mode),
    .W_I(w), .CMP_I(cmp), .XCHG_O(xo), .XCHG_DATA_O(xd), .WAKE_PEND_O(wp),
    .SLEEP_I(slp), .WDT_OVF_I(wdt), .POWER_DOWN_O(pdo), .WAKE_O(wko),
    .RESTART_PC_O(rpc), .CNT_WRAP_I(wrp), .CNT_IRQ_EN_I(cen), .CNT_PEND_CLR_I(cclr),
    .CNT_PEND_O(cpo), .TMR_EVENT_I(tev), .BOUNDARY_I(bnd), .PC_I(pc), .FPTR_I(fptr),
    .STATUS_I(st), .RETURN_I(rti), .RETURN_ADD_I(rtw), .VECTOR_O(vo), .VEC_PC_O(vpc),
    .VEC_STATUS_O(vs), .RESTORE_O(ro), .RST_PC_O(rp), .RST_FPTR_O(rf),
    .RST_STATUS_O(rs), .RST_MODE_O(rm), .RST_W_O(rw), .CNT_ADD_O(cao),
    .CNT_ADD_VAL_O(cav), .IN_SERVICE_O(iso)
  );

  ////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pins that should latch for a level change
  function automatic byte_t hits(byte_t a, byte_t b, byte_t e, byte_t m);
    return ~m & ((e & a & ~b) | (~e & ~a & b));
  endfunction : hits

  task automatic chk(input string nm, input logic [43:0] seen, input logic [43:0] want);
    checked++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic pls(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pls

  // port-control move, checks the swap answer and tracks the model
  task automatic mov(input byte_t m, input byte_t d);
    logic sx;
    sx = (m == `PWIC_MODE_PEND) || (m == `PWIC_MODE_CMP);
    cmp = 8'($urandom);
    mode = m;
    w = d;
    mv = 1'b1;
    tick(1);
    mv = 1'b0;
    chk("xchg", xo, sx);
    // pending content before the first clear is unknown and not compared
    if (m == `PWIC_MODE_PEND && !$isunknown(ep))
    begin
      chk("xdata", xd, ep);
    end
    if (m == `PWIC_MODE_CMP)
    begin
      chk("xdata", xd, cmp);
    end
    if (m == `PWIC_MODE_PEND) ep = d;
    if (m == `PWIC_MODE_EDGE) ed = d;
    if (m == `PWIC_MODE_ENABLE) en = d;
    chk("pend", wp, ep);
    // one idle edge so the next move raises its strobe on a fresh cycle
    tick(1);
  endtask : mov

  // pin change, long enough for sync stages and latch
  task automatic pin(input byte_t v);
    ep = ep | hits(lvl, v, ed, en);
    lvl = v;
    tick(6);
  endtask : pin

  task automatic ent(input logic e);
    bnd = 1'b1;
    tick(1);
    bnd = 1'b0;
    chk("vector", vo, e);
    tick(1);
  endtask : ent

  task automatic waitw();
    for (int i = 0; i < 12 && wko !== 1'b1; i++) tick(1);
    chk("wake", wko, 1'b1);
    chk("pdown", pdo, 1'b0);
    chk("restart", rpc, `PWIC_PC_MAX);
  endtask : waitw

  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  // watchdog: the full sequence needs well under 3000 cycles
  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    {mv, slp, wdt, wrp, cen, cclr, bnd, rti, rtw, tev} = '0;
    {mode, w, cmp, fptr, st, pc} = '0;
    lvl = 8'hFF;
    ep = 'x;
    ed = `PWIC_EDGE_RST;
    en = `PWIC_ENABLE_RST;
    rst = 1'b1;
    void'($urandom(32'hED3FA418));
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(3);
    chk("idle", {pdo, iso, cpo, xd}, 11'h000);
    // masked by reset: no edge pends; defaults are falling
    mov(`PWIC_MODE_PEND, 8'h00);
    pin(8'($urandom));
    chk("pend", wp, 8'h00);
    mov(`PWIC_MODE_ENABLE, 8'h00);
    pin(8'($urandom));
    chk("pend", wp, ep);
    // random edge, mask and pin patterns, plus compare swap and a dead mode
    repeat (8)
    begin
      mov(`PWIC_MODE_EDGE, 8'($urandom));
      mov(`PWIC_MODE_PEND, 8'h00);
      mov(`PWIC_MODE_ENABLE, 8'($urandom));
      repeat (3) pin(8'($urandom));
      chk("pend", wp, ep);
      mov(`PWIC_MODE_CMP, 8'($urandom));
      mov(8'h1C, 8'($urandom));
    end
    // external interrupt entry, nested edge, timer drop, both returns
    mov(`PWIC_MODE_ENABLE, 8'hFF);
    mov(`PWIC_MODE_EDGE, 8'hFF);
    pin(8'hFF);
    mov(`PWIC_MODE_PEND, 8'h00);
    mov(`PWIC_MODE_ENABLE, 8'hFC);
    pin(8'hFE);
    {pc, fptr, st, w, mode} = 44'({$urandom, $urandom});
    sw = w;
    ent(1'b1);
    chk("vpc", vpc, `PWIC_ISR_VECTOR);
    chk("vstat", vs, st & ~`PWIC_PAGE_MASK);
    chk("saved", {rp, rf, rs, rm, rw}, {pc, fptr, st, mode, sw});
    chk("service", iso, 1'b1);
    tev = `PWIC_TMR_SRC'($urandom | 1);
    tick(1);
    tev = '0;
    mov(`PWIC_MODE_PEND, 8'h00);
    pin(8'hFC);
    chk("pend", wp, 8'h02);
    ent(1'b0);
    w = 8'($urandom);
    pls(rtw);
    chk("ret", {ro, cao, iso, cav}, {3'b110, sw});
    ent(1'b1);
    mov(`PWIC_MODE_PEND, 8'h00);
    pls(rti);
    chk("ret", {ro, cao, iso}, 3'b100);
    ent(1'b0);
    // counter wrap pends always, interrupts only when enabled
    pls(wrp);
    chk("cpend", cpo, 1'b1);
    ent(1'b0);
    cen = 1'b1;
    ent(1'b1);
    pls(cclr);
    chk("cpend", cpo, 1'b0);
    pls(rti);
    tev = `PWIC_TMR_SRC'(1);
    tick(1);
    tev = '0;
    ent(1'b1);
    pls(rti);
    // power down: wrong edge keeps sleeping, selected edge and watchdog wake
    pls(slp);
    chk("pdown", pdo, 1'b1);
    pin(8'hFE);
    chk("pdown", pdo, 1'b1);
    ep = ep | hits(lvl, 8'hFC, ed, en);
    lvl = 8'hFC;
    waitw();
    tick(3);
    mov(`PWIC_MODE_PEND, 8'h00);
    pls(slp);
    pls(wdt);
    waitw();
    end_of_test();
  end
endmodule : tb_top
